// file: design/dcpi_core.sv
// Command, address and control pin interface of the memory device.
// Assumes ck is the true pin clock; the complement is resolved off-chip.
// Assumes write data beats are held at least two core cycles per strobe edge.
`timescale 1ns/1ps
`default_nettype none
module dcpi_core
#(
	parameter int DQ_W = dcpi_pkg::DCPI_DQ_W
)
(
	input  wire logic                             clock,
	input  wire logic                             rst_n,
	input  wire logic                             ck,
	input  wire logic                             cke,
	input  wire logic                             cs_n,
	input  wire logic                             ras_n,
	input  wire logic                             cas_n,
	input  wire logic                             we_n,
	input  wire logic [dcpi_pkg::DCPI_BA_W-1:0]   ba,
	input  wire logic [dcpi_pkg::DCPI_ADDR_W-1:0] addr,
	input  wire logic                             termination_enable,
	input  wire logic                             dm,
	input  wire logic [DQ_W-1:0]                  dq_i,
	output logic      [DQ_W-1:0]                  dq_o,
	output logic                                  dq_oe,
	input  wire logic                             dqs_i,
	output logic                                  dqs_o,
	output logic                                  dqs_oe,
	output logic                                  term_on,
	output logic                                  term_strobe_en,
	output logic                                  cmd_buf_en,
	output logic                                  odt_buf_en,
	output logic                                  clk_buf_en,
	output logic                                  core_en,
	output dcpi_pkg::dcpi_pwr_type                pwr_state,
	output logic      [dcpi_pkg::DCPI_NBANK-1:0]  bank_open,
	output logic      [dcpi_pkg::DCPI_NMR*dcpi_pkg::DCPI_ADDR_W-1:0] mode_regs,
	output logic                                  cmd_err
);
	import dcpi_pkg::*;

	localparam int MEM_AW = DCPI_BA_W + 1 + DCPI_COL_W;
	localparam int MEM_N  = 1 << MEM_AW;

	typedef struct packed {
		logic                                   req_s1;
		logic                                   req_s2;
		logic                                   req_s3;
		logic                                   ack_tgl;
		logic                                   cke_s1;
		logic                                   cke_s2;
		logic                                   odt_s1;
		logic                                   odt_s2;
		logic                                   dm_s1;
		logic                                   dm_s2;
		logic                                   dqs_s1;
		logic                                   dqs_s2;
		logic                                   dqs_s3;
		logic [DQ_W-1:0]                        dq_s1;
		logic [DQ_W-1:0]                        dq_s2;
		dcpi_pwr_type                           pwr;
		logic [DCPI_NBANK-1:0]                  open;
		logic [DCPI_NBANK-1:0]                  row_lsb;
		logic [DCPI_NMR-1:0][DCPI_ADDR_W-1:0]   mr;
		logic                                   bst;
		logic                                   bst_wr;
		logic                                   bst_ap;
		logic [3:0]                             left;
		logic [DCPI_COL_W-1:0]                  col;
		logic [DCPI_BA_W-1:0]                   bank;
		logic [MEM_N-1:0][DQ_W-1:0]             mem;
		logic [DQ_W-1:0]                        dq_o;
		logic                                   dq_oe;
		logic                                   dqs_o;
		logic                                   dqs_oe;
		logic                                   term_on;
		logic                                   termination_strobe_en;
		logic                                   cmd_buf_en;
		logic                                   odt_buf_en;
		logic                                   clk_buf_en;
		logic                                   core_en;
		logic                                   cmd_err;
	} dcpi_core_type;

	dcpi_core_type r_r;
	dcpi_core_type r_nxt;
	dcpi_word_type w;
	logic          new_cmd;
	logic          any_open;
	logic          mask_on;
	logic          rtt_off;
	logic [3:0]    beats;
	logic [MEM_AW-1:0] idx;

	dcpi_xfer_if xif ();

	// ==========================================================
	// Pin-clock command capture
	dcpi_link u_link
	(
		.ck    (ck),
		.rst_n (rst_n),
		.cke   (cke),
		.cs_n  (cs_n),
		.ras_n (ras_n),
		.cas_n (cas_n),
		.we_n  (we_n),
		.ba    (ba),
		.addr  (addr),
		.xif   (xif.link)
	);

	assign xif.ack_tgl = r_r.ack_tgl;
	assign xif.in_pd   = (r_r.pwr == DCPI_PWR_PD_PRE) || (r_r.pwr == DCPI_PWR_PD_ACT);
	assign xif.in_sr   = (r_r.pwr == DCPI_PWR_SELF_REF);
	assign w           = xif.word;

	// ==========================================================
	// Next state
	always_comb
	begin
		r_nxt       = r_r;
		r_nxt.req_s1 = xif.req_tgl;
		r_nxt.req_s2 = r_r.req_s1;
		r_nxt.req_s3 = r_r.req_s2;
		r_nxt.cke_s1 = cke;
		r_nxt.cke_s2 = r_r.cke_s1;
		r_nxt.odt_s1 = termination_enable;
		r_nxt.odt_s2 = r_r.odt_s1;
		r_nxt.dm_s1  = dm;
		r_nxt.dm_s2  = r_r.dm_s1;
		r_nxt.dqs_s1 = dqs_i;
		r_nxt.dqs_s2 = r_r.dqs_s1;
		r_nxt.dqs_s3 = r_r.dqs_s2;
		r_nxt.dq_s1  = dq_i;
		r_nxt.dq_s2  = r_r.dq_s1;
		r_nxt.cmd_err = 1'b0;
		r_nxt.dq_oe  = 1'b0;
		r_nxt.dqs_oe = 1'b0;
		r_nxt.dqs_o  = 1'b0;

		new_cmd  = (r_r.req_s2 != r_r.req_s3);
		any_open = |r_r.open;
		rtt_off  = !(r_r.mr[1][DCPI_MR1_RTT0_BIT] | r_r.mr[1][DCPI_MR1_RTT1_BIT] | r_r.mr[1][DCPI_MR1_RTT2_BIT]);
		mask_on  = !r_r.termination_strobe_en;
		idx      = {r_r.bank, r_r.row_lsb[r_r.bank], r_r.col};

		// Burst length from mode register 0 and address bit twelve
		case (r_r.mr[0][DCPI_MR0_BL_LSB +: 2])
			DCPI_BL_OTF:  beats = w.addr[DCPI_BC_BIT] ? DCPI_BEATS_8 : DCPI_BEATS_4;
			DCPI_BL_FIX4: beats = DCPI_BEATS_4;
			default:      beats = DCPI_BEATS_8;
		endcase

		// Data beats of a running burst
		if (r_r.bst)
		begin
			if (r_r.bst_wr)
			begin
				if (r_r.dqs_s2 != r_r.dqs_s3)
				begin
					if (!(mask_on && r_r.dm_s2))
						r_nxt.mem[idx] = r_r.dq_s2;
					r_nxt.col  = r_r.col + 3'h1;
					r_nxt.left = r_r.left - 4'h1;
				end
			end
			else
			begin
				r_nxt.dq_o   = r_r.mem[idx];
				r_nxt.dq_oe  = 1'b1;
				r_nxt.dqs_oe = 1'b1;
				r_nxt.dqs_o  = !r_r.col[0];
				r_nxt.col    = r_r.col + 3'h1;
				r_nxt.left   = r_r.left - 4'h1;
			end
			if (r_nxt.left == 4'h0)
			begin
				r_nxt.bst = 1'b0;
				if (r_r.bst_ap)
					r_nxt.open[r_r.bank] = 1'b0;
			end
		end

		// Decoded commands
		if (new_cmd)
		begin
			r_nxt.ack_tgl = r_r.req_s2;
			case (w.cmd)
				DCPI_CMD_MODE_LOAD:
				begin
					if (any_open || w.ba[2])
						r_nxt.cmd_err = 1'b1;
					else
						r_nxt.mr[w.ba[1:0]] = w.addr;
				end
				DCPI_CMD_ACTIVATE:
				begin
					if (r_r.open[w.ba])
						r_nxt.cmd_err = 1'b1;
					else
					begin
						r_nxt.open[w.ba]    = 1'b1;
						r_nxt.row_lsb[w.ba] = w.addr[0];
					end
				end
				DCPI_CMD_PRECHARGE:
				begin
					if (w.addr[DCPI_AP_BIT])
						r_nxt.open = '0;
					else
						r_nxt.open[w.ba] = 1'b0;
				end
				DCPI_CMD_READ,
				DCPI_CMD_WRITE:
				begin
					if (!r_r.open[w.ba] || r_r.bst)
						r_nxt.cmd_err = 1'b1;
					else
					begin
						r_nxt.bst    = 1'b1;
						r_nxt.bst_wr = (w.cmd == DCPI_CMD_WRITE);
						r_nxt.bst_ap = w.addr[DCPI_AP_BIT];
						r_nxt.bank   = w.ba;
						r_nxt.col    = w.addr[DCPI_COL_W-1:0];
						r_nxt.left   = beats;
					end
				end
				DCPI_CMD_REFRESH:
					r_nxt.cmd_err = any_open;
				DCPI_CMD_PD_ENTER:
					if (r_r.pwr == DCPI_PWR_ACTIVE)
						r_nxt.pwr = any_open ? DCPI_PWR_PD_ACT : DCPI_PWR_PD_PRE;
				DCPI_CMD_SR_ENTER:
				begin
					if (any_open)
					begin
						r_nxt.cmd_err = 1'b1;
						r_nxt.pwr     = DCPI_PWR_PD_ACT;
					end
					else
						r_nxt.pwr = DCPI_PWR_SELF_REF;
				end
				DCPI_CMD_PD_EXIT:
					if (r_r.pwr != DCPI_PWR_SELF_REF)
						r_nxt.pwr = DCPI_PWR_ACTIVE;
				DCPI_CMD_ZQ_CAL:
					r_nxt.cmd_err = 1'b0;
				default:
					r_nxt.cmd_err = 1'b1;
			endcase
		end

		// Self refresh leaves on the synchronised gate alone
		if ((r_r.pwr == DCPI_PWR_SELF_REF) && r_r.cke_s2)
			r_nxt.pwr = DCPI_PWR_ACTIVE;

		// Buffer gating and termination
		r_nxt.core_en    = (r_nxt.pwr == DCPI_PWR_ACTIVE);
		r_nxt.cmd_buf_en = (r_nxt.pwr == DCPI_PWR_ACTIVE);
		r_nxt.odt_buf_en = (r_nxt.pwr != DCPI_PWR_SELF_REF);
		r_nxt.clk_buf_en = (r_nxt.pwr != DCPI_PWR_SELF_REF);
		r_nxt.termination_strobe_en    = (DQ_W == 8) && r_nxt.mr[1][DCPI_MR1_TERMINATION_STROBE_BIT];
		r_nxt.term_on    = r_r.odt_s2 && !rtt_off && (r_r.pwr != DCPI_PWR_SELF_REF);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	// ==========================================================
	// Outputs straight from the state register
	always_comb
	begin
		dq_o           = r_r.dq_o;
		dq_oe          = r_r.dq_oe;
		dqs_o          = r_r.dqs_o;
		dqs_oe         = r_r.dqs_oe;
		term_on        = r_r.term_on;
		term_strobe_en = r_r.termination_strobe_en;
		cmd_buf_en     = r_r.cmd_buf_en;
		odt_buf_en     = r_r.odt_buf_en;
		clk_buf_en     = r_r.clk_buf_en;
		core_en        = r_r.core_en;
		pwr_state      = r_r.pwr;
		bank_open      = r_r.open;
		mode_regs      = r_r.mr;
		cmd_err        = r_r.cmd_err;
	end

endmodule : dcpi_core
`default_nettype wire

// file: design/dcpi_pkg.sv
// Shared constants and types for the command pin interface.
// Assumes one package, compiled before the interface and modules.
package dcpi_pkg;

	// ==========================================================
	// Widths
	localparam int DCPI_ADDR_W  = 14;
	localparam int DCPI_BA_W    = 3;
	localparam int DCPI_NBANK   = 8;
	localparam int DCPI_NMR     = 4;
	localparam int DCPI_DQ_W    = 8;
	localparam int DCPI_COL_W   = 3;

	// ==========================================================
	// Address bit positions
	localparam int DCPI_AP_BIT  = 10;
	localparam int DCPI_BC_BIT  = 12;

	// ==========================================================
	// Mode register fields
	localparam int         DCPI_MR0_BL_LSB   = 0;
	localparam logic [1:0] DCPI_BL_FIX8      = 2'h0;
	localparam logic [1:0] DCPI_BL_OTF       = 2'h1;
	localparam logic [1:0] DCPI_BL_FIX4      = 2'h2;
	localparam int         DCPI_MR1_RTT0_BIT = 2;
	localparam int         DCPI_MR1_RTT1_BIT = 6;
	localparam int         DCPI_MR1_RTT2_BIT = 9;
	localparam int         DCPI_MR1_TERMINATION_STROBE_BIT = 11;
	localparam logic [DCPI_ADDR_W-1:0] DCPI_MR_RST = 14'h0000;

	// ==========================================================
	// Burst lengths in beats
	localparam logic [3:0] DCPI_BEATS_8 = 4'h8;
	localparam logic [3:0] DCPI_BEATS_4 = 4'h4;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		DCPI_CMD_NONE,
		DCPI_CMD_MODE_LOAD,
		DCPI_CMD_REFRESH,
		DCPI_CMD_PRECHARGE,
		DCPI_CMD_ACTIVATE,
		DCPI_CMD_WRITE,
		DCPI_CMD_READ,
		DCPI_CMD_ZQ_CAL,
		DCPI_CMD_PD_ENTER,
		DCPI_CMD_PD_EXIT,
		DCPI_CMD_SR_ENTER
	} dcpi_cmd_type;

	typedef enum logic [1:0] {
		DCPI_PWR_ACTIVE,
		DCPI_PWR_PD_PRE,
		DCPI_PWR_PD_ACT,
		DCPI_PWR_SELF_REF
	} dcpi_pwr_type;

	typedef struct packed {
		dcpi_cmd_type                 cmd;
		logic [DCPI_BA_W-1:0]         ba;
		logic [DCPI_ADDR_W-1:0]       addr;
	} dcpi_word_type;

endpackage : dcpi_pkg

// file: design/dcpi_xfer_if.sv
// Crossing between the pin-clock capture and the core clock.
// Assumes toggle request and toggle acknowledge, word held while pending.
`timescale 1ns/1ps
`default_nettype none
interface dcpi_xfer_if;
	import dcpi_pkg::*;
	logic          req_tgl;
	logic          ack_tgl;
	dcpi_word_type word;
	logic          in_pd;
	logic          in_sr;

	modport link
	(
		output req_tgl,
		output word,
		input  ack_tgl,
		input  in_pd,
		input  in_sr
	);

	modport core
	(
		input  req_tgl,
		input  word,
		output ack_tgl,
		output in_pd,
		output in_sr
	);
endinterface : dcpi_xfer_if
`default_nettype wire

// file: design/dcpi_link.sv
// Command capture on the memory clock and hand-off to the core.
// Assumes control pins are launched by the controller on ck.
`timescale 1ns/1ps
`default_nettype none
module dcpi_link
(
	input  wire logic                          ck,
	input  wire logic                          rst_n,
	input  wire logic                          cke,
	input  wire logic                          cs_n,
	input  wire logic                          ras_n,
	input  wire logic                          cas_n,
	input  wire logic                          we_n,
	input  wire logic [dcpi_pkg::DCPI_BA_W-1:0]   ba,
	input  wire logic [dcpi_pkg::DCPI_ADDR_W-1:0] addr,
	dcpi_xfer_if.link                          xif
);
	import dcpi_pkg::*;

	typedef struct packed {
		logic          prev_cke;
		logic          pd_s1;
		logic          pd_s2;
		logic          sr_s1;
		logic          sr_s2;
		logic          ack_s1;
		logic          ack_s2;
		logic          req_tgl;
		logic          busy;
		dcpi_word_type word;
	} dcpi_link_type;

	dcpi_link_type r;
	dcpi_link_type nxt;
	dcpi_cmd_type  pin_cmd;

	// ==========================================================
	// Command decode from select and strobes
	always_comb
	begin
		if (cs_n)
			pin_cmd = DCPI_CMD_NONE;
		else
		begin
			case ({ras_n, cas_n, we_n})
				3'h0:    pin_cmd = DCPI_CMD_MODE_LOAD;
				3'h1:    pin_cmd = DCPI_CMD_REFRESH;
				3'h2:    pin_cmd = DCPI_CMD_PRECHARGE;
				3'h3:    pin_cmd = DCPI_CMD_ACTIVATE;
				3'h4:    pin_cmd = DCPI_CMD_WRITE;
				3'h5:    pin_cmd = DCPI_CMD_READ;
				3'h6:    pin_cmd = DCPI_CMD_ZQ_CAL;
				default: pin_cmd = DCPI_CMD_NONE;
			endcase
		end
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt          = r;
		nxt.pd_s1    = xif.in_pd;
		nxt.pd_s2    = r.pd_s1;
		nxt.sr_s1    = xif.in_sr;
		nxt.sr_s2    = r.sr_s1;
		nxt.ack_s1   = xif.ack_tgl;
		nxt.ack_s2   = r.ack_s1;
		nxt.prev_cke = cke;
		if (r.busy && (r.ack_s2 == r.req_tgl))
			nxt.busy = 1'b0;
		if (!r.busy && !r.sr_s2)
		begin
			if (r.prev_cke && !cke)
			begin
				nxt.word.cmd = (pin_cmd == DCPI_CMD_REFRESH) ? DCPI_CMD_SR_ENTER : DCPI_CMD_PD_ENTER;
				nxt.busy     = 1'b1;
			end
			else if (!r.prev_cke && cke && r.pd_s2)
			begin
				nxt.word.cmd = DCPI_CMD_PD_EXIT;
				nxt.busy     = 1'b1;
			end
			else if (r.prev_cke && cke && !r.pd_s2 && (pin_cmd != DCPI_CMD_NONE))
			begin
				nxt.word.cmd = pin_cmd;
				nxt.busy     = 1'b1;
			end
			if (nxt.busy)
			begin
				nxt.word.ba   = ba;
				nxt.word.addr = addr;
				nxt.req_tgl   = ~r.req_tgl;
			end
		end
	end

	always_ff @(posedge ck or negedge rst_n)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= nxt;
	end

	assign xif.req_tgl = r.req_tgl;
	assign xif.word    = r.word;

endmodule : dcpi_link
`default_nettype wire

// file: verif/dcpi_core_asserts.sv
// Concurrent checks on the top-level ports of the command pin interface.
// Assumes it is bound into dcpi_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dcpi_core_asserts
#(
	parameter int DQ_W = 8
)
(
	input wire logic                                                 clock,
	input wire logic                                                 rst_n,
	input wire logic                                                 cke,
	input wire logic                                                 termination_enable,
	input wire logic                                                 dq_oe,
	input wire logic                                                 dqs_oe,
	input wire logic                                                 term_on,
	input wire logic                                                 term_strobe_en,
	input wire logic                                                 cmd_buf_en,
	input wire logic                                                 odt_buf_en,
	input wire logic                                                 clk_buf_en,
	input wire logic                                                 core_en,
	input var  dcpi_pkg::dcpi_pwr_type                               pwr_state,
	input wire logic [dcpi_pkg::DCPI_NBANK-1:0]                      bank_open,
	input wire logic [dcpi_pkg::DCPI_NMR*dcpi_pkg::DCPI_ADDR_W-1:0] mode_regs,
	input wire logic                                                 cmd_err
);
	import dcpi_pkg::*;
	localparam int M1 = DCPI_ADDR_W;
	logic rtt_on;
	assign rtt_on = mode_regs[M1+DCPI_MR1_RTT0_BIT] | mode_regs[M1+DCPI_MR1_RTT1_BIT] | mode_regs[M1+DCPI_MR1_RTT2_BIT];
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// =====
	// Read burst shapes
	sequence s_bc4;
		dq_oe [*4] ##1 !dq_oe;
	endsequence
	sequence s_bl8;
		dq_oe [*8] ##1 !dq_oe;
	endsequence

	// =====
	// Checks
	a_reset_idle: assert property ($rose(rst_n) |-> bank_open == '0 && pwr_state == DCPI_PWR_ACTIVE)
		else $error("state not idle after reset");
	a_active_bufs: assert property (pwr_state == DCPI_PWR_ACTIVE [*3] |-> cmd_buf_en && clk_buf_en && core_en)
		else $error("enables off while active");
	a_pd_bufs: assert property (pwr_state inside {DCPI_PWR_PD_PRE, DCPI_PWR_PD_ACT} [*3]
		|-> !cmd_buf_en && clk_buf_en && odt_buf_en)
		else $error("wrong buffers in power-down");
	a_sr_bufs: assert property (pwr_state == DCPI_PWR_SELF_REF [*3] |-> !cmd_buf_en && !clk_buf_en && !odt_buf_en)
		else $error("wrong buffers in self refresh");
	a_sr_exit: assert property (pwr_state == DCPI_PWR_SELF_REF && cke |-> ##[1:8] pwr_state == DCPI_PWR_ACTIVE)
		else $error("no exit from self refresh");
	a_pd_frozen: assert property (pwr_state != DCPI_PWR_ACTIVE && $past(pwr_state) != DCPI_PWR_ACTIVE
		|-> $stable(bank_open))
		else $error("bank state changed while powered down");
	a_term_off: assert property (!termination_enable [*6] |-> !term_on)
		else $error("termination on with enable low");
	a_term_ignore: assert property (!rtt_on [*3] |-> !term_on)
		else $error("termination on while disabled");
	a_strobe_cfg: assert property ($stable(mode_regs) [*3]
		|-> term_strobe_en == (DQ_W == 8 && mode_regs[M1+DCPI_MR1_TERMINATION_STROBE_BIT]))
		else $error("termination strobe mismatch");
	a_burst_len: assert property ($rose(dq_oe) |-> s_bc4 or s_bl8)
		else $error("read burst length wrong");
	a_fixed_len: assert property ($rose(dq_oe) && mode_regs[1:0] == DCPI_BL_FIX8 |-> s_bl8)
		else $error("fixed burst not eight");
	a_strobe_edge: assert property (dqs_oe |-> dq_oe)
		else $error("strobe driven without data");
	a_err_pulse: assert property (cmd_err |=> !cmd_err)
		else $error("error flag longer than a cycle");
endmodule : dcpi_core_asserts

bind dcpi_core dcpi_core_asserts #(.DQ_W(DQ_W)) u_chk
(
	.clock(clock), .rst_n(rst_n), .cke(cke), .termination_enable(termination_enable), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
	.term_on(term_on), .term_strobe_en(term_strobe_en), .cmd_buf_en(cmd_buf_en),
	.odt_buf_en(odt_buf_en), .clk_buf_en(clk_buf_en), .core_en(core_en), .pwr_state(pwr_state),
	.bank_open(bank_open), .mode_regs(mode_regs), .cmd_err(cmd_err)
);
`default_nettype wire

// file: verif/dcpi_ctrl_model.sv
// Memory controller model: makes the pin clock and drives commands on it.
// Assumes the bench calls cmd and gate, and may stop the clock via run.
`timescale 1ns/1ps
`default_nettype none
module dcpi_ctrl_model
(
	output logic                             ck,
	output logic                             cke,
	output logic                             cs_n,
	output logic                             ras_n,
	output logic                             cas_n,
	output logic                             we_n,
	output logic [dcpi_pkg::DCPI_BA_W-1:0]   ba,
	output logic [dcpi_pkg::DCPI_ADDR_W-1:0] addr
);
	import dcpi_pkg::*;
	logic run = 1'b1;
	initial
	begin
		ck = 1'b0;
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		ba = '0;
		addr = '0;
	end
	always #3 if (run) ck = ~ck;

	// One command for one pin clock, then idle with lines turned over
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		@(posedge ck);
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		@(posedge ck);
		{cs_n, ras_n, cas_n, we_n} <= 4'h7;
		ba <= ~b;
		addr <= ~a;
	endtask : cmd

	task automatic gate(input logic v, input logic [3:0] c);
		@(posedge ck);
		cke <= v;
		{cs_n, ras_n, cas_n, we_n} <= c;
		@(posedge ck);
		{cs_n, ras_n, cas_n, we_n} <= 4'h7;
	endtask : gate
endmodule : dcpi_ctrl_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the command pin interface.
// Assumes dcpi_core as top and the controller model on the pin clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcpi_pkg::*;
	localparam logic [3:0] MRS = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
	localparam logic [3:0] WR = 4'h4, RD = 4'h5, NOP = 4'h7, DSEL = 4'hB;
	logic                   clock = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   termination_enable = 1'b0;
	logic                   dm = 1'b0;
	logic                   dqs_i = 1'b0;
	logic                   err_seen = 1'b0;
	logic [7:0]             dq_i = 8'h00;
	logic [7:0]             dq_o;
	logic [7:0]             mem [8];
	logic                   dq_oe, dqs_o, dqs_oe, term_on, term_strobe_en, cmd_err;
	logic                   cmd_buf_en, odt_buf_en, clk_buf_en, core_en;
	logic                   ck, cke, cs_n, ras_n, cas_n, we_n;
	logic [DCPI_BA_W-1:0]   ba, bk;
	logic [DCPI_ADDR_W-1:0] addr, row, mr0;
	logic [DCPI_ADDR_W-1:0] mrv [4];
	logic [DCPI_ADDR_W-1:0] tv [5] = '{14'h0040, 14'h0200, 14'h0000, 14'h0800, 14'h0004};
	logic [7:0]             bank_open;
	logic [55:0]            mode_regs;
	dcpi_pwr_type           pwr_state;
	logic [31:0]            seed = 32'h893F;
	int                     fail_count = 0;
	int                     tests_run = 0;

	always #12.5 clock = ~clock;
	always @(posedge clock) if (cmd_err === 1'b1) err_seen <= 1'b1;

	dcpi_ctrl_model ctl
	(
		.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr)
	);
	dcpi_core #(.DQ_W(8)) uut
	(
		.clock(clock), .rst_n(rst_n), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .termination_enable(termination_enable), .dm(dm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
		.dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .term_on(term_on), .term_strobe_en(term_strobe_en),
		.cmd_buf_en(cmd_buf_en), .odt_buf_en(odt_buf_en), .clk_buf_en(clk_buf_en), .core_en(core_en),
		.pwr_state(pwr_state), .bank_open(bank_open), .mode_regs(mode_regs), .cmd_err(cmd_err)
	);

	// =====
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic int beats(input logic [1:0] bl, input logic a12);
		return (bl == DCPI_BL_FIX4 || (bl == DCPI_BL_OTF && !a12)) ? 4 : 8;
	endfunction : beats
	function automatic dcpi_pwr_type pd_exp(input logic open);
		return open ? DCPI_PWR_PD_ACT : DCPI_PWR_PD_PRE;
	endfunction : pd_exp
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask : w
	task automatic op(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		ctl.cmd(c, b, a);
		w(12);
	endtask : op
	task automatic tally_and_finish();
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// Eight write beats from column zero; beat mb carries the mask
	task automatic wr(input int mb);
		ctl.cmd(WR, bk, 14'h1000);
		w(8);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			dq_i <= seed[7:0];
			dm <= (i == mb);
			dqs_i <= ~dqs_i;
			if (i != mb)
				mem[i] = seed[7:0];
			w(3);
		end
		dm <= 1'b0;
		w(8);
	endtask : wr
	task automatic rd(input logic a12, input logic ap);
		int n;
		n = 0;
		ctl.cmd(RD, bk, {1'b0, a12, 1'b0, ap, 10'h000});
		repeat (40)
		begin
			@(posedge clock);
			dq_i <= ~dq_i;
			#1;
			if (dq_oe === 1'b1)
			begin
				chk(dq_o, mem[n[2:0]]);
				chk({dqs_oe, dqs_o}, {1'b1, ~n[0]});
				n++;
			end
		end
		chk(n, beats(mr0[1:0], a12));
	endtask : rd

	// =====
	// Main sequence
	initial
	begin
		w(2);
		#1;
		chk(pwr_state, DCPI_PWR_ACTIVE);
		chk(cmd_buf_en, 1'b0);
		w(2);
		rst_n <= 1'b1;
		w(4);
		chk(cmd_buf_en, 1'b1);
		seed = xs(seed);
		mr0 = 14'h0001;
		mrv = '{mr0, 14'h0004, seed[13:0], seed[27:14]};
		for (int k = 0; k < 4; k++)
		begin
			op(MRS, 3'(k), mrv[k]);
			chk(mode_regs[k*DCPI_ADDR_W +: DCPI_ADDR_W], mrv[k]);
		end
		err_seen <= 1'b0;
		op(MRS, 3'h4, 14'h3FFF);
		chk(err_seen, 1'b1);
		chk(mode_regs, {mrv[3], mrv[2], mrv[1], mrv[0]});
		termination_enable <= 1'b1;
		foreach (tv[i])
		begin
			op(MRS, 3'h1, tv[i]);
			chk(term_on, tv[i][2] | tv[i][6] | tv[i][9]);
			chk(term_strobe_en, tv[i][11]);
		end
		termination_enable <= 1'b0;
		w(8);
		chk(term_on, 1'b0);
		seed = xs(seed);
		bk = seed[30:28];
		row = seed[13:0];
		op(DSEL, bk, row);
		chk(bank_open, 8'h00);
		op(ACT, bk, row);
		chk(bank_open, 8'h01 << bk);
		wr(8);
		wr(3);
		rd(1'b1, 1'b0);
		rd(1'b0, 1'b1);
		chk(bank_open, 8'h00);
		mr0 = 14'h0002;
		op(MRS, 3'h0, mr0);
		op(ACT, bk, row);
		rd(1'b1, 1'b1);
		chk(bank_open, 8'h00);
		mr0 = 14'h0000;
		op(MRS, 3'h0, mr0);
		op(ACT, bk, row);
		rd(1'b0, 1'b0);
		op(ACT, bk ^ 3'h1, row);
		op(PRE, bk, 14'h0000);
		chk(bank_open, 8'h01 << (bk ^ 3'h1));
		ctl.gate(1'b0, NOP);
		w(12);
		chk(pwr_state, pd_exp(1'b1));
		chk({cmd_buf_en, odt_buf_en, clk_buf_en}, 3'b011);
		op(ACT, bk, row);
		chk(bank_open, 8'h01 << (bk ^ 3'h1));
		ctl.gate(1'b1, NOP);
		w(12);
		chk(pwr_state, DCPI_PWR_ACTIVE);
		op(PRE, 3'h0, 14'h0400); // Close every row first
		chk(bank_open, 8'h00);
		ctl.gate(1'b0, NOP);
		w(12);
		chk(pwr_state, pd_exp(1'b0));
		ctl.gate(1'b1, NOP);
		w(12);
		ctl.gate(1'b0, REF);
		w(12);
		chk(pwr_state, DCPI_PWR_SELF_REF);
		chk({cmd_buf_en, odt_buf_en, clk_buf_en}, 3'b000);
		ctl.run <= 1'b0;
		w(4);
		ctl.cke <= 1'b1;
		w(12);
		chk(pwr_state, DCPI_PWR_ACTIVE);
		ctl.run <= 1'b1;
		w(4);
		tally_and_finish();
	end

	initial
	begin
		#100us;
		fail_count++;
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
